// ==== verilog/cdsl_core.sv ====
// current demand selection, trim and limiting with avalon register slave
//
// Function
// - speed mode: signed demand of plus/minus 1000 feeds current loop
// - demand restricted by symmetric, positive and negative bridge limits
// - read-only final demand after all limits, sent to current loop
// - overriding limit is lowest of taper, symmetric and selected second limit
// - symmetric limit 0..1000, reset 1000, both bridges, taper datum
// - positive bridge limit 0..1000, reset 1000, caps positive demand
// - negative bridge limit 0..1000, reset 1000, caps negative demand
// - second limit 0..1000, reset 1000, both bridges when selected
// - torque reference plus/minus 1000, reset zero, for torque modes
// - offset plus/minus 1000 added as trim when selector is one
// - second limit in force when selector bit is one; auto set allowed
// - two mode bits: speed, torque, torque with override, coiler
// - speed mode routes speed loop output as the demand
// - torque mode feeds torque reference under all limits
// - override mode clamps speed output to torque ref or zero
// - override motoring quadrants limit speed to final speed demand
// - override regen quadrants disable torque demand below speed demand
// - torque reference acts as adjustable limit on speed output
// - auto changeover selects second limit after interval from run
// - changeover interval is whole seconds 0..255 from run command
// - coiler mode forces zero speed reference when torque opposes speed
`timescale 1ns/100ps
`default_nettype none
module cdsl_core #(
  parameter int TICK_CYC = cdsl_pkg::TICK_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [cdsl_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic signed [15:0] speed_loop_out_i,
  input wire logic signed [15:0] speed_error_i,
  input wire logic signed [15:0] speed_feedback_i,
  input wire logic signed [15:0] final_speed_demand_i,
  input wire logic signed [15:0] taper_limit_i,
  input wire logic run_i,
  output logic signed [15:0] final_demand_o,
  output logic speed_ref_zero_o
);
  import cdsl_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] sym;
    logic [15:0] pos;
    logic [15:0] neg;
    logic [15:0] lim2;
    logic signed [15:0] torque;
    logic signed [15:0] trim;
    logic lim2_sel;
    logic trim_sel;
    logic [1:0] mode;
    logic auto_en;
    logic [7:0] interval;
    cdsl_tmr_e tmr;
    logic [31:0] cyc;
    logic [7:0] secs;
    logic run_q1;
    logic run_q2;
    logic run_q3;
    logic signed [15:0] demand;
    logic signed [15:0] final_d;
    logic signed [15:0] ovr;
    logic zero_ref;
    logic ack;
    logic [31:0] rdata;
  } cdsl_state_s;

  cdsl_state_s r;
  cdsl_state_s next_r;

  // clamp a signed value into [lo, hi]
  function automatic logic signed [15:0] clampv(
    input logic signed [15:0] v,
    input logic signed [15:0] lo,
    input logic signed [15:0] hi
  );
    logic signed [15:0] t;
    t = v;
    if (t > hi) begin
      t = hi;
    end
    if (t < lo) begin
      t = lo;
    end
    return t;
  endfunction

  // smaller of two signed values
  function automatic logic signed [15:0] minv(
    input logic signed [15:0] a,
    input logic signed [15:0] b
  );
    return (a < b) ? a : b;
  endfunction

  // limit a written signed value to plus/minus full scale
  function automatic logic [15:0] wr_bi(input logic [15:0] w);
    return 16'(clampv(signed'(w), -FULL_SCALE, FULL_SCALE));
  endfunction

  // limit a written unipolar value to 0..full scale
  function automatic logic [15:0] wr_uni(input logic [15:0] w);
    return 16'(clampv(signed'(w), ZERO_VAL, FULL_SCALE));
  endfunction

  logic signed [15:0] sel_d;
  logic signed [16:0] sum_d;
  logic signed [15:0] trimmed;
  logic signed [15:0] env;
  logic signed [15:0] ovr_c;
  logic signed [15:0] hi_lim;
  logic signed [15:0] lo_lim;
  logic wr_hit;
  logic rd_hit;

  // ----------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------
  // selection, trim and limits; the sum is one bit wider so the trim
  // can never wrap before saturation
  always_comb begin
    ovr_c = minv(taper_limit_i, signed'(r.sym));
    if (r.lim2_sel) begin
      ovr_c = minv(ovr_c, signed'(r.lim2));
    end
    sel_d = speed_loop_out_i;
    case (cdsl_mode_e'(r.mode))
      CDSL_SPEED: sel_d = speed_loop_out_i;
      CDSL_TORQUE: sel_d = r.torque;
      CDSL_OVERRIDE: begin
        // torque ref bounds speed output; sign disagreements give zero
        if (r.torque >= ZERO_VAL) begin
          sel_d = clampv(speed_loop_out_i, ZERO_VAL, r.torque);
        end else begin
          sel_d = clampv(speed_loop_out_i, r.torque, ZERO_VAL);
        end
        // regen: torque opposes speed, speed below demand -> no current
        if ((r.torque[15] != speed_feedback_i[15]) &&
            (speed_feedback_i < final_speed_demand_i)) begin
          sel_d = ZERO_VAL;
        end
        // motoring: speed error sign caps speed at final demand
        if ((r.torque[15] == speed_feedback_i[15]) &&
            (speed_error_i[15] != r.torque[15]) &&
            (speed_error_i != ZERO_VAL)) begin
          sel_d = ZERO_VAL;
        end
      end
      CDSL_COILER: sel_d = speed_loop_out_i;
      default: sel_d = speed_loop_out_i;
    endcase
    sum_d = 17'(sel_d);
    if (r.trim_sel) begin
      sum_d = 17'(sel_d) + 17'(r.trim);
    end
    if (sum_d > 17'(FULL_SCALE)) begin
      trimmed = FULL_SCALE;
    end else if (sum_d < -17'(FULL_SCALE)) begin
      trimmed = -FULL_SCALE;
    end else begin
      trimmed = sum_d[15:0];
    end
    env = minv(ovr_c, signed'(r.sym));
    hi_lim = minv(env, signed'(r.pos));
    lo_lim = -minv(env, signed'(r.neg));
  end

  // ----------------------------------------------------------------
  // register bus decode
  // ----------------------------------------------------------------
  // one wait state; a write commits only where waitrequest is low
  assign wr_hit = avs_write_i && r.ack;
  assign rd_hit = avs_read_i && !r.ack;
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !r.ack;
  assign avs_readdata_o = r.rdata;
  assign final_demand_o = r.final_d;
  assign speed_ref_zero_o = r.zero_ref;

  // next state: registers, timer, datapath outputs
  always_comb begin
    next_r = r;
    next_r.ack = (avs_read_i || avs_write_i) && !r.ack;
    next_r.run_q1 = run_i;
    next_r.run_q2 = r.run_q1;
    next_r.run_q3 = r.run_q2;
    next_r.demand = trimmed;
    next_r.final_d = clampv(trimmed, lo_lim, hi_lim);
    next_r.ovr = ovr_c;
    // coiler: zero speed reference when torque opposes speed
    next_r.zero_ref = (r.mode == 2'(CDSL_COILER)) &&
      (speed_loop_out_i != ZERO_VAL) && (speed_feedback_i != ZERO_VAL) &&
      (speed_loop_out_i[15] != speed_feedback_i[15]);
    // run-triggered changeover timer, one-second tick
    case (r.tmr)
      CDSL_IDLE: begin
        if (r.auto_en && r.run_q2 && !r.run_q3) begin
          next_r.tmr = CDSL_TIMING;
          next_r.cyc = '0;
          next_r.secs = '0;
        end
      end
      CDSL_TIMING: begin
        if (!r.auto_en || !r.run_q2) begin
          next_r.tmr = CDSL_IDLE;
        end else if (r.secs >= r.interval) begin
          next_r.lim2_sel = 1'b1;
          next_r.tmr = CDSL_DONE;
        end else if (r.cyc >= 32'(TICK_CYC - 1)) begin
          next_r.cyc = '0;
          next_r.secs = r.secs + 8'h01;
        end else begin
          next_r.cyc = r.cyc + 32'h0000_0001;
        end
      end
      CDSL_DONE: begin
        if (!r.run_q2) begin
          next_r.tmr = CDSL_IDLE;
        end
      end
      default: next_r.tmr = CDSL_IDLE;
    endcase
    // writes; byte lanes 0 and 1 carry the 16-bit value
    if (wr_hit && avs_byteenable_i[0]) begin
      case (avs_address_i)
        OFF_SYM: next_r.sym = wr_uni(avs_writedata_i[15:0]);
        OFF_POS: next_r.pos = wr_uni(avs_writedata_i[15:0]);
        OFF_NEG: next_r.neg = wr_uni(avs_writedata_i[15:0]);
        OFF_LIM2: next_r.lim2 = wr_uni(avs_writedata_i[15:0]);
        OFF_TORQUE: next_r.torque = wr_bi(avs_writedata_i[15:0]);
        OFF_TRIM: next_r.trim = wr_bi(avs_writedata_i[15:0]);
        OFF_CTRL: begin
          next_r.lim2_sel = avs_writedata_i[BIT_LIM2_SEL];
          next_r.trim_sel = avs_writedata_i[BIT_TRIM_SEL];
          next_r.mode = {avs_writedata_i[BIT_MODE_HI],
                         avs_writedata_i[BIT_MODE_LO]};
          next_r.auto_en = avs_writedata_i[BIT_AUTO_EN];
        end
        OFF_TIMER: next_r.interval = avs_writedata_i[7:0];
        default: next_r.sym = r.sym;
      endcase
    end
    // the timer's automatic set wins over a same-cycle clear
    if (r.tmr == CDSL_TIMING && r.auto_en && r.run_q2 &&
        r.secs >= r.interval) begin
      next_r.lim2_sel = 1'b1;
    end
    if (rd_hit) begin
      case (avs_address_i)
        OFF_DEMAND: next_r.rdata = 32'(r.demand);
        OFF_FINAL: next_r.rdata = 32'(r.final_d);
        OFF_OVERRIDE: next_r.rdata = 32'(r.ovr);
        OFF_SYM: next_r.rdata = {16'h0000, r.sym};
        OFF_POS: next_r.rdata = {16'h0000, r.pos};
        OFF_NEG: next_r.rdata = {16'h0000, r.neg};
        OFF_LIM2: next_r.rdata = {16'h0000, r.lim2};
        OFF_TORQUE: next_r.rdata = 32'(r.torque);
        OFF_TRIM: next_r.rdata = 32'(r.trim);
        OFF_CTRL: next_r.rdata = {27'h000_0000, r.auto_en, r.mode,
                                  r.trim_sel, r.lim2_sel};
        OFF_TIMER: next_r.rdata = {24'h00_0000, r.interval};
        default: next_r.rdata = 32'h0000_0000;
      endcase
    end
  end

  // state register
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
      r.sym <= LIMIT_RESET;
      r.pos <= LIMIT_RESET;
      r.neg <= LIMIT_RESET;
      r.lim2 <= LIMIT_RESET;
      r.interval <= TIMER_RESET;
      r.tmr <= CDSL_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_final_in_range: assert property (
    final_demand_o <= FULL_SCALE && final_demand_o >= -FULL_SCALE)
    else $error("final demand out of range");
  a_pos_bridge_cap: assert property (
    ##1 (final_demand_o <= signed'($past(r.pos))))
    else $error("final demand above positive bridge limit");
  a_neg_bridge_cap: assert property (
    ##1 (final_demand_o >= -signed'($past(r.neg))))
    else $error("final demand below negative bridge limit");
  a_sym_limit_cap: assert property (
    ##1 (final_demand_o <= signed'($past(r.sym)) &&
         final_demand_o >= -signed'($past(r.sym))))
    else $error("final demand outside symmetric limit");
  a_lim2_when_sel: assert property (
    r.lim2_sel |=> (final_demand_o <= signed'($past(r.lim2))))
    else $error("second limit not applied");
  a_speed_mode_path: assert property (
    (r.mode == 2'b00 && !r.trim_sel &&
     speed_loop_out_i <= ZERO_VAL && speed_loop_out_i >= ZERO_VAL)
    |=> final_demand_o == ZERO_VAL)
    else $error("speed mode demand not routed");
  a_torque_mode_path: assert property (
    (r.mode == 2'b01 && !r.trim_sel)
    |=> r.demand == $past(r.torque))
    else $error("torque mode demand not routed");
  a_override_clamp: assert property (
    (r.mode == 2'b10 && !r.trim_sel && r.torque >= ZERO_VAL)
    |=> (r.demand <= $past(r.torque) && r.demand >= ZERO_VAL))
    else $error("override clamp broken");
  a_auto_select: assert property (
    (r.tmr == CDSL_TIMING && r.auto_en && r.run_q2 &&
     r.secs >= r.interval) |=> r.lim2_sel)
    else $error("auto changeover missed");
  a_bus_answer: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus answer late");

  c_speed_mode: cover property (r.mode == 2'b00 && r.final_d != ZERO_VAL);
  c_torque_mode: cover property (r.mode == 2'b01 && r.torque != ZERO_VAL);
  c_override: cover property (r.mode == 2'b10 && r.demand != ZERO_VAL);
  c_changeover: cover property (r.tmr == CDSL_DONE);
endmodule
`default_nettype wire

// ==== inc/cdsl_pkg.sv ====
// package of constants for the current demand select and limit stage
package cdsl_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 6;
  localparam logic signed [15:0] FULL_SCALE = 16'sh03e8;
  localparam logic signed [15:0] ZERO_VAL = 16'sh0000;
  localparam logic [15:0] LIMIT_RESET = 16'h03e8;
  // register byte offsets (word aligned)
  localparam logic [5:0] OFF_DEMAND = 6'h00;
  localparam logic [5:0] OFF_FINAL = 6'h04;
  localparam logic [5:0] OFF_OVERRIDE = 6'h08;
  localparam logic [5:0] OFF_SYM = 6'h0c;
  localparam logic [5:0] OFF_POS = 6'h10;
  localparam logic [5:0] OFF_NEG = 6'h14;
  localparam logic [5:0] OFF_LIM2 = 6'h18;
  localparam logic [5:0] OFF_TORQUE = 6'h1c;
  localparam logic [5:0] OFF_TRIM = 6'h20;
  localparam logic [5:0] OFF_CTRL = 6'h24;
  localparam logic [5:0] OFF_TIMER = 6'h28;
  // control register bit positions
  localparam int BIT_LIM2_SEL = 0;
  localparam int BIT_TRIM_SEL = 1;
  localparam int BIT_MODE_LO = 2;
  localparam int BIT_MODE_HI = 3;
  localparam int BIT_AUTO_EN = 4;
  // timing
  localparam int CLK_HZ = 200_000_000;
  localparam int SEC_PER_TICK = 1;
  localparam int TICK_CYCLES = CLK_HZ * SEC_PER_TICK;
  localparam logic [7:0] TIMER_RESET = 8'h00;
  typedef enum logic [1:0] {
    CDSL_SPEED, CDSL_TORQUE, CDSL_OVERRIDE, CDSL_COILER
  } cdsl_mode_e;
  typedef enum logic [1:0] {
    CDSL_IDLE, CDSL_TIMING, CDSL_DONE
  } cdsl_tmr_e;
endpackage

// ==== tb/cdsl_loop_model.sv ====
// partner model: speed loop upstream, current loop downstream
`timescale 1ns/100ps
`default_nettype none
module cdsl_loop_model (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [79:0] cmd_i,
  input wire logic signed [15:0] demand_i,
  output logic signed [15:0] spd_o,
  output logic signed [15:0] err_o,
  output logic signed [15:0] fb_o,
  output logic signed [15:0] fsd_o,
  output logic signed [15:0] taper_o,
  output logic signed [15:0] seen_o
);
  // speed loop values leave a register, as real same-domain logic would;
  // the current loop side registers the final demand it receives
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      seen_o <= 16'sh0000;
    end else begin
      seen_o <= demand_i;
    end
  end
  // upstream values are not reset: the bench holds them valid throughout
  always_ff @(posedge ref_clk_i) begin
    {spd_o, err_o, fb_o, fsd_o, taper_o} <= cmd_i;
  end
endmodule
`default_nettype wire

// ==== tb/current_demand_select_limit_bench.sv ====
// self-checking bench for the current demand select and limit stage
`timescale 1ns/100ps
`default_nettype none
module current_demand_select_limit_bench;
  import cdsl_pkg::*;
  localparam int TICK = 10;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] be = 4'hf;
  logic run = 1'b0;
  logic [79:0] cmd = {64'h0, 16'h03e8};
  logic [31:0] rdata;
  logic wait_r;
  logic zref;
  logic signed [15:0] spd, err, fb, fsd, tap, seen, fin, v;
  logic [15:0] expq[$];
  string nq[$];
  logic [31:0] lf = 32'hcb7f_983b;
  int n_fail = 0;
  int total_checks = 0;
  // ---------------------------------------------------------------
  // design, partner and clock
  // ---------------------------------------------------------------
  cdsl_core #(.TICK_CYC(TICK)) dut_u (.ref_clk_i(ref_clk_i),
    .rst_i(rst_i), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_r),
    .speed_loop_out_i(spd), .speed_error_i(err), .speed_feedback_i(fb),
    .final_speed_demand_i(fsd), .taper_limit_i(tap), .run_i(run),
    .final_demand_o(fin), .speed_ref_zero_o(zref));
  cdsl_loop_model loop_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .cmd_i(cmd), .demand_i(fin), .spd_o(spd), .err_o(err), .fb_o(fb),
    .fsd_o(fsd), .taper_o(tap), .seen_o(seen));
  always #2.5 ref_clk_i = ~ref_clk_i;
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic signed [15:0] clip(input logic signed [15:0] x,
    input logic signed [15:0] lo, input logic signed [15:0] hi);
    return (x > hi) ? hi : ((x < lo) ? lo : x);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp_v,
    input string what);
    total_checks++;
    if (got !== exp_v) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp_v, got);
    end
  endtask
  // one Avalon transfer; request held until waitrequest is seen low,
  // with no cycle limit of its own: only the watchdog ends a hang
  task automatic bus(input logic w, input logic [5:0] a,
    input logic [31:0] d, input logic [3:0] b);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= d;
    be <= b;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge ref_clk_i);
    end while (wait_r !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wreg(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask
  // the expected word is queued before the read is issued
  task automatic rreg(input logic [5:0] a, input logic [15:0] e,
    input string s);
    expq.push_back(e);
    nq.push_back(s);
    bus(1'b0, a, 32'h0000_0000, 4'hf);
  endtask
  // new upstream values, then time for model and datapath registers
  task automatic drv(input logic signed [15:0] s, e, f, fs, t);
    @(posedge ref_clk_i);
    cmd <= {s, e, f, fs, t};
    repeat (4) @(posedge ref_clk_i);
  endtask
  // read results are compared at the edge where they are taken
  always @(posedge ref_clk_i) begin
    if (rd && wait_r === 1'b0 && expq.size() > 0) begin
      chk(rdata[15:0], expq.pop_front(), nq.pop_front());
    end
  end
  task automatic close_out;
    // reads still waiting for an answer count as mismatches
    n_fail += expq.size();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #100000;
    n_fail++;
    close_out();
  end
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rreg(OFF_SYM, 16'h03e8, "sym reset");
    rreg(OFF_POS, 16'h03e8, "pos reset");
    rreg(OFF_NEG, 16'h03e8, "neg reset");
    rreg(OFF_LIM2, 16'h03e8, "lim2 reset");
    rreg(OFF_TORQUE, 16'h0000, "torque reset");
    rreg(OFF_TRIM, 16'h0000, "trim reset");
    rreg(OFF_CTRL, 16'h0000, "ctrl reset");
    rreg(6'h3c, 16'h0000, "unmapped");
    // speed mode with random demand against unequal bridge limits
    wreg(OFF_POS, 32'h0000_012c);
    wreg(OFF_NEG, 32'h0000_00c8);
    for (int i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      v = $signed(lf[15:0]) % 16'sh03e9;
      drv(v, 16'sh0000, 16'sh0000, 16'sh0000, 16'sh03e8);
      rreg(OFF_DEMAND, v, "demand");
      rreg(OFF_FINAL, clip(v, -16'sh00c8, 16'sh012c), "final");
      chk(seen, clip(v, -16'sh00c8, 16'sh012c), "loop demand");
    end
    // symmetric limit, and a write with byte 0 disabled is ignored
    wreg(OFF_SYM, 32'h0000_0064);
    bus(1'b1, OFF_SYM, 32'h0000_01f4, 4'h0);
    rreg(OFF_SYM, 16'h0064, "sym kept");
    drv(-16'sh02bc, 16'sh0000, 16'sh0000, 16'sh0000, 16'sh03e8);
    rreg(OFF_FINAL, -16'sh0064, "sym clamp");
    wreg(OFF_SYM, 32'h0000_03e8);
    // trim added to a speed demand
    wreg(OFF_TRIM, 32'h0000_0032);
    wreg(OFF_CTRL, 32'h0000_0002);
    drv(16'sh0064, 16'sh0000, 16'sh0000, 16'sh0000, 16'sh03e8);
    rreg(OFF_FINAL, 16'h0096, "trim");
    // torque mode: an oversize write saturates, bridge limit applies
    wreg(OFF_TORQUE, 32'h0000_07d0);
    rreg(OFF_TORQUE, 16'h03e8, "torque sat");
    wreg(OFF_TORQUE, 32'h0000_0190);
    wreg(OFF_CTRL, 32'h0000_0004);
    rreg(OFF_FINAL, 16'h012c, "torque mode");
    // second limit and the overriding limit against the taper
    wreg(OFF_LIM2, 32'h0000_0096);
    wreg(OFF_CTRL, 32'h0000_0001);
    drv(-16'sh0384, 16'sh0000, 16'sh0000, 16'sh0000, 16'sh0258);
    rreg(OFF_FINAL, -16'sh0096, "lim2");
    rreg(OFF_OVERRIDE, 16'h0096, "override lim2");
    wreg(OFF_CTRL, 32'h0000_0000);
    rreg(OFF_OVERRIDE, 16'h0258, "override taper");
    // torque with speed override: clamp, motoring cut, regen cut
    wreg(OFF_POS, 32'h0000_03e8);
    wreg(OFF_CTRL, 32'h0000_0008);
    drv(16'sh02bc, 16'sh0032, 16'sh0064, 16'sh0000, 16'sh03e8);
    rreg(OFF_FINAL, 16'h0190, "ovr clamp");
    drv(16'sh02bc, -16'sh0032, 16'sh0064, 16'sh0000, 16'sh03e8);
    rreg(OFF_FINAL, 16'h0000, "ovr motoring");
    wreg(OFF_TORQUE, 32'hffff_fe70);
    drv(-16'sh02bc, -16'sh0032, 16'sh0064, 16'sh012c, 16'sh03e8);
    rreg(OFF_FINAL, 16'h0000, "ovr regen");
    // coiler mode zero speed reference request
    wreg(OFF_CTRL, 32'h0000_000c);
    drv(-16'sh012c, 16'sh0000, 16'sh00c8, 16'sh0000, 16'sh03e8);
    chk({15'h0, zref}, 16'h0001, "coiler zero");
    drv(16'sh012c, 16'sh0000, 16'sh00c8, 16'sh0000, 16'sh03e8);
    chk({15'h0, zref}, 16'h0000, "coiler run");
    // timed changeover two ticks after run
    wreg(OFF_CTRL, 32'h0000_0010);
    wreg(OFF_TIMER, 32'h0000_0002);
    run <= 1'b1;
    rreg(OFF_CTRL, 16'h0010, "before interval");
    rreg(OFF_TIMER, 16'h0002, "interval");
    repeat (TICK) @(posedge ref_clk_i);
    rreg(OFF_CTRL, 16'h0010, "mid interval");
    repeat (2 * TICK + 12) @(posedge ref_clk_i);
    rreg(OFF_CTRL, 16'h0011, "after interval");
    run <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    close_out();
  end
endmodule
`default_nettype wire
